// ==== include/l1cd_cfg.svh ====
`ifndef L1CD_CFG_SVH
`define L1CD_CFG_SVH

`define L1CD_SETS 128
`define L1CD_WAYS 8
`define L1CD_TAG_W 20
`define L1CD_FILL_BEATS 4
`define L1CD_OFF_CTRL 8'h00
`define L1CD_OFF_ATTR 8'h04
`define L1CD_OFF_EADDR 8'h08
`define L1CD_OFF_PADDR 8'h0c
`define L1CD_OFF_CMD 8'h10
`define L1CD_OFF_STATUS 8'h14
`define L1CD_CTRL_RST 2'h0
`define L1CD_ATTR_RST 18'h00000
`define L1CD_REAL_MODE_ATTR 4'h3
`define L1CD_TT_CI_READ 4'ha
`define L1CD_CMD_SPEC_BIT 8
`define L1CD_ATTR_IBLK_BIT 16
`define L1CD_ATTR_DBLK_BIT 17

`endif

// ==== include/l1cd_pkg.sv ====
package l1cd_pkg;

    typedef enum logic [1:0] {
        COH_INV = 2'b00,
        COH_EXCL = 2'b01,
        COH_MOD = 2'b10
    } l1cd_coh_e;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_FILL = 2'b10
    } l1cd_state_e;

    typedef enum logic [2:0] {
        OP_ILOOK = 3'b000,
        OP_DLOOK = 3'b001,
        OP_IFILL = 3'b010,
        OP_DFILL = 3'b011,
        OP_DSTORE = 3'b100,
        OP_INVAL = 3'b101
    } l1cd_op_e;

    typedef struct packed {
        logic wrThrough;
        logic cacheInh;
        logic coherent;
        logic guarded;
    } l1cd_attr_s;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
        logic global;
        logic rwitm;
    } l1cd_busreq_s;

endpackage : l1cd_pkg

// ==== hdl/l1cd_attr.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "l1cd_cfg.svh"

module l1cd_attr #(
    parameter bit HAS_GUARD = 1'b1
) (
    input wire logic transEn,
    input wire logic useBlock,
    input wire logic [3:0] pageAttr,
    input wire logic [3:0] blockAttr,
    output l1cd_pkg::l1cd_attr_s attr
);
    logic [3:0] picked;

    always_comb
    begin
        picked = useBlock ? blockAttr : pageAttr;
        if (!transEn)
        begin
            picked = `L1CD_REAL_MODE_ATTR;
        end
        else if (useBlock && !HAS_GUARD)
        begin
            picked[0] = 1'b0;
        end
        attr = l1cd_pkg::l1cd_attr_s'(picked);
    end

endmodule : l1cd_attr

`default_nettype wire

// ==== hdl/l1cd_top.sv ====
// Functional notes
// - Instruction directory: 128 sets by 8 ways, valid bit and tag per 32-byte line.
// - Lines are eight-word aligned; fill address names the critical double word; low three address bits zero.
// - Instruction lookup: A[20-26] picks set, A[27-29] picks word in line.
// - Tags hold PA[0-19]; set selection uses untranslated index bits.
// - Instruction directory keeps only valid bit and ignores all snoops.
// - Four attribute bits per block or page from block register or page entry.
// - Translation off gives attributes 0b0011: write-back, cacheable, coherent, guarded.
// - Instruction block translation pairs have no guard; treated as not guarded.
// - Coherency attribute selects global or local bus transaction for data fills; instruction fills always go local.
// - Guarded locations get no speculative loads or prefetches.
// - Data lookup indexes by A[20-26], compares 20 tag bits in all ways.
// - Two state bits per data line: modified, exclusive, invalid; no shared.
// - Modified line is newer than memory and held by no other cache.
// - Exclusive line matches memory and is owned only here.
// - Data line fills go out as read-with-intent-to-modify.
// - Completed fill leaves line exclusive; stores then need no bus broadcast.
// - Snooped global hit: modified copies back and invalidates, exclusive invalidates.
// - Snooped inhibited read X1010 on modified line: copy back, become exclusive.
// - Snooped inhibited read on exclusive line: no bus action, stays exclusive.
// - Snoop only when transfer start and global asserted in same clock.
// - Fill takes four 64-bit beats, critical double word first and forwarded.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "l1cd_cfg.svh"

module l1cd_top #(
    parameter int SETS = `L1CD_SETS,
    parameter int WAYS = `L1CD_WAYS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic transferStartN,
    input wire logic globalAttributeN,
    input wire logic [4:0] transferTypeCode,
    input wire logic [31:0] snoopAddr,
    input wire logic fillBeatValid,
    input wire logic [63:0] fillData,
    output logic fwdValid,
    output logic [63:0] fwdData,
    output l1cd_pkg::l1cd_busreq_s busReq,
    output logic copyBackReq,
    output logic [31:0] copyBackAddr
);
    localparam int SW = $clog2(SETS);
    localparam int WW = $clog2(WAYS);
    localparam int TW = `L1CD_TAG_W;

    // Directory storage; data arrays live elsewhere
    logic iValid_r [SETS*WAYS];
    logic [TW-1:0] iTag_r [SETS*WAYS];
    l1cd_pkg::l1cd_coh_e dState_r [SETS*WAYS];
    logic [TW-1:0] dTag_r [SETS*WAYS];

    l1cd_pkg::l1cd_state_e state_r;
    logic [SW-1:0] initSet_r;
    logic [1:0] ctrl_r;
    logic [17:0] attrCfg_r;
    logic [31:0] ea_r;
    logic [TW-1:0] pa_r;
    logic lkHit_r;
    logic [1:0] lkState_r;
    logic [WW-1:0] lkWay_r;
    logic refused_r;
    logic fillIsData_r;
    logic [WW-1:0] fillWay_r;
    logic [SW-1:0] fillSet_r;
    logic [TW-1:0] fillTag_r;
    logic [1:0] critDw_r;
    logic [1:0] beatCnt_r;
    logic installPend_r;
    logic [1:0] tsS1_r, tsS2_r;
    logic [4:0] ttS1_r, ttS2_r;
    logic [31:0] saS1_r, saS2_r;

    l1cd_pkg::l1cd_attr_s iAttr, dAttr;
    logic [SW-1:0] lkSet;
    logic iHit, dHit, sHit;
    logic [WW-1:0] iWay, dWay, sWay;
    logic snoopGo, ciRead;
    logic apbWr, cmdWr, cmdExec;
    l1cd_pkg::l1cd_op_e cmdOp;
    logic [WW-1:0] cmdWay;
    logic cmdSpec;
    logic [31:0] rdVal;
    logic rdErr;

    l1cd_attr #(
        .HAS_GUARD(1'b0)
    ) u_iattr (
        .transEn(ctrl_r[0]),
        .useBlock(attrCfg_r[`L1CD_ATTR_IBLK_BIT]),
        .pageAttr(attrCfg_r[3:0]),
        .blockAttr(attrCfg_r[11:8]),
        .attr(iAttr)
    );

    l1cd_attr #(
        .HAS_GUARD(1'b1)
    ) u_dattr (
        .transEn(ctrl_r[1]),
        .useBlock(attrCfg_r[`L1CD_ATTR_DBLK_BIT]),
        .pageAttr(attrCfg_r[7:4]),
        .blockAttr(attrCfg_r[15:12]),
        .attr(dAttr)
    );

    // Set from untranslated bits while the tag comes from translation
    assign lkSet = ea_r[SW+4:5];

    always_comb
    begin
        iHit = 1'b0;
        iWay = '0;
        dHit = 1'b0;
        dWay = '0;
        for (int w = 0; w < WAYS; w++)
        begin
            if (iValid_r[{lkSet, WW'(w)}] && iTag_r[{lkSet, WW'(w)}] == pa_r)
            begin
                iHit = 1'b1;
                iWay = WW'(w);
            end
            if (dState_r[{lkSet, WW'(w)}] != l1cd_pkg::COH_INV
                && dTag_r[{lkSet, WW'(w)}] == pa_r)
            begin
                dHit = 1'b1;
                dWay = WW'(w);
            end
        end
    end

    // Snoop pins come from the shared bus: two flops before use
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tsS1_r <= 2'h3;
            tsS2_r <= 2'h3;
            ttS1_r <= 5'h00;
            ttS2_r <= 5'h00;
            saS1_r <= 32'h00000000;
            saS2_r <= 32'h00000000;
        end
        else
        begin
            tsS1_r <= {transferStartN, globalAttributeN};
            tsS2_r <= tsS1_r;
            ttS1_r <= transferTypeCode;
            ttS2_r <= ttS1_r;
            saS1_r <= snoopAddr;
            saS2_r <= saS1_r;
        end
    end

    assign snoopGo = (tsS2_r == 2'h0) && (state_r != l1cd_pkg::ST_INIT);
    assign ciRead = (ttS2_r[3:0] == `L1CD_TT_CI_READ);

    // Only the data directory is searched; instruction side never sees snoops
    always_comb
    begin
        sHit = 1'b0;
        sWay = '0;
        for (int w = 0; w < WAYS; w++)
        begin
            if (dState_r[{saS2_r[SW+4:5], WW'(w)}] != l1cd_pkg::COH_INV
                && dTag_r[{saS2_r[SW+4:5], WW'(w)}] == saS2_r[31:32-TW])
            begin
                sHit = 1'b1;
                sWay = WW'(w);
            end
        end
    end

    assign apbWr = psel && penable && pready && pwrite;
    assign cmdWr = apbWr && (paddr == `L1CD_OFF_CMD);
    // Snoop owns the single tag port this cycle; software must retry
    assign cmdExec = cmdWr && !snoopGo && (state_r == l1cd_pkg::ST_IDLE);
    assign cmdOp = l1cd_pkg::l1cd_op_e'(pwdata[2:0]);
    assign cmdWay = pwdata[WW+3:4];
    assign cmdSpec = pwdata[`L1CD_CMD_SPEC_BIT];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= l1cd_pkg::ST_INIT;
            initSet_r <= '0;
        end
        else
        begin
            case (state_r)
                l1cd_pkg::ST_INIT:
                begin
                    initSet_r <= initSet_r + 1'b1;
                    if (initSet_r == SW'(SETS - 1))
                    begin
                        state_r <= l1cd_pkg::ST_IDLE;
                    end
                end
                l1cd_pkg::ST_IDLE:
                begin
                    if (cmdExec && cmdOp == l1cd_pkg::OP_INVAL)
                    begin
                        state_r <= l1cd_pkg::ST_INIT;
                    end
                    else if (busReq.req)
                    begin
                        state_r <= l1cd_pkg::ST_FILL;
                    end
                end
                l1cd_pkg::ST_FILL:
                begin
                    if (fillBeatValid && beatCnt_r == 2'(`L1CD_FILL_BEATS - 1))
                    begin
                        state_r <= l1cd_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= l1cd_pkg::ST_INIT;
                end
            endcase
        end
    end

    // Directory writes: init, then snoop, then fill install, then store
    always_ff @(posedge clk)
    begin
        if (state_r == l1cd_pkg::ST_INIT)
        begin
            for (int w = 0; w < WAYS; w++)
            begin
                iValid_r[{initSet_r, WW'(w)}] <= 1'b0;
                dState_r[{initSet_r, WW'(w)}] <= l1cd_pkg::COH_INV;
            end
        end
        else if (snoopGo)
        begin
            if (sHit)
            begin
                // Inhibited reads keep the line to avoid thrashing
                dState_r[{saS2_r[SW+4:5], sWay}] <= ciRead ? l1cd_pkg::COH_EXCL
                                                            : l1cd_pkg::COH_INV;
            end
        end
        else if (installPend_r)
        begin
            if (fillIsData_r)
            begin
                dTag_r[{fillSet_r, fillWay_r}] <= fillTag_r;
                dState_r[{fillSet_r, fillWay_r}] <= l1cd_pkg::COH_EXCL;
            end
            else
            begin
                iTag_r[{fillSet_r, fillWay_r}] <= fillTag_r;
                iValid_r[{fillSet_r, fillWay_r}] <= 1'b1;
            end
        end
        else if (cmdExec && cmdOp == l1cd_pkg::OP_DSTORE && dHit && !dAttr.cacheInh)
        begin
            // Write-through stores leave the state as it is
            if (!dAttr.wrThrough)
            begin
                dState_r[{lkSet, dWay}] <= l1cd_pkg::COH_MOD;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            copyBackReq <= 1'b0;
            copyBackAddr <= 32'h00000000;
        end
        else
        begin
            copyBackReq <= snoopGo && sHit
                && dState_r[{saS2_r[SW+4:5], sWay}] == l1cd_pkg::COH_MOD;
            if (snoopGo && sHit)
            begin
                copyBackAddr <= {saS2_r[31:5], 5'h00};
            end
        end
    end

    // Fill request and beat sequencing
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            busReq <= '0;
            fillIsData_r <= 1'b0;
            fillWay_r <= '0;
            fillSet_r <= '0;
            fillTag_r <= '0;
            critDw_r <= 2'h0;
            beatCnt_r <= 2'h0;
            installPend_r <= 1'b0;
            fwdValid <= 1'b0;
            fwdData <= 64'h0000000000000000;
        end
        else
        begin
            busReq.req <= 1'b0;
            fwdValid <= 1'b0;
            if (installPend_r && !snoopGo)
            begin
                installPend_r <= 1'b0;
            end
            if (cmdExec && !refusedNow() && !installPend_r
                && (cmdOp == l1cd_pkg::OP_IFILL || cmdOp == l1cd_pkg::OP_DFILL))
            begin
                fillIsData_r <= (cmdOp == l1cd_pkg::OP_DFILL);
                fillWay_r <= cmdWay;
                fillSet_r <= lkSet;
                fillTag_r <= pa_r;
                critDw_r <= ea_r[4:3];
                beatCnt_r <= 2'h0;
                busReq.req <= 1'b1;
                busReq.addr <= {pa_r, lkSet, ea_r[4:3], 3'h0};
                busReq.rwitm <= (cmdOp == l1cd_pkg::OP_DFILL);
                // Instruction fetches never go out global
                busReq.global <= (cmdOp == l1cd_pkg::OP_DFILL) && dAttr.coherent;
            end
            if (state_r == l1cd_pkg::ST_FILL && fillBeatValid)
            begin
                beatCnt_r <= beatCnt_r + 2'h1;
                if (beatCnt_r == 2'h0)
                begin
                    fwdValid <= 1'b1;
                    fwdData <= fillData;
                end
                if (beatCnt_r == 2'(`L1CD_FILL_BEATS - 1))
                begin
                    installPend_r <= 1'b1;
                end
            end
        end
    end

    function automatic logic refusedNow();
        logic isFill;
        isFill = (cmdOp == l1cd_pkg::OP_IFILL) || (cmdOp == l1cd_pkg::OP_DFILL);
        if (cmdOp == l1cd_pkg::OP_IFILL)
        begin
            refusedNow = iAttr.cacheInh || (cmdSpec && iAttr.guarded);
        end
        else if (cmdOp == l1cd_pkg::OP_DFILL)
        begin
            refusedNow = dAttr.cacheInh || (cmdSpec && dAttr.guarded);
        end
        else
        begin
            refusedNow = 1'b0;
        end
        refusedNow = refusedNow || (isFill && installPend_r);
    endfunction : refusedNow

    // Software registers and lookup results
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_r <= `L1CD_CTRL_RST;
            attrCfg_r <= `L1CD_ATTR_RST;
            ea_r <= 32'h00000000;
            pa_r <= '0;
            lkHit_r <= 1'b0;
            lkState_r <= 2'h0;
            lkWay_r <= '0;
            refused_r <= 1'b0;
        end
        else
        begin
            if (apbWr && paddr == `L1CD_OFF_CTRL)
            begin
                ctrl_r <= pwdata[1:0];
            end
            if (apbWr && paddr == `L1CD_OFF_ATTR)
            begin
                attrCfg_r <= pwdata[17:0];
            end
            if (apbWr && paddr == `L1CD_OFF_EADDR)
            begin
                ea_r <= pwdata;
            end
            if (apbWr && paddr == `L1CD_OFF_PADDR)
            begin
                pa_r <= pwdata[TW-1:0];
            end
            if (cmdWr)
            begin
                refused_r <= !cmdExec || refusedNow();
            end
            if (cmdExec && cmdOp == l1cd_pkg::OP_ILOOK)
            begin
                lkHit_r <= iHit && !iAttr.cacheInh;
                lkState_r <= {1'b0, iHit};
                lkWay_r <= iWay;
            end
            else if (cmdExec && (cmdOp == l1cd_pkg::OP_DLOOK || cmdOp == l1cd_pkg::OP_DSTORE))
            begin
                // Inhibited accesses behave as misses
                lkHit_r <= dHit && !dAttr.cacheInh;
                lkState_r <= dHit ? dState_r[{lkSet, dWay}] : l1cd_pkg::COH_INV;
                lkWay_r <= dWay;
            end
        end
    end

    always_comb
    begin
        rdErr = 1'b0;
        rdVal = 32'h00000000;
        case (paddr)
            `L1CD_OFF_CTRL: rdVal = {30'h0, ctrl_r};
            `L1CD_OFF_ATTR: rdVal = {14'h0, attrCfg_r};
            `L1CD_OFF_EADDR: rdVal = ea_r;
            `L1CD_OFF_PADDR: rdVal = {12'h0, pa_r};
            `L1CD_OFF_CMD: rdVal = 32'h00000000;
            `L1CD_OFF_STATUS: rdVal = {7'h0, dAttr, iAttr, 3'h0, ea_r[4:2], 1'b0,
                                       refused_r, state_r, installPend_r,
                                       lkWay_r, lkState_r, lkHit_r};
            default: rdErr = 1'b1;
        endcase
    end

    // No wait state: answer registered in the setup cycle, ready in the first access cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && rdErr;
            prdata <= (psel && !penable && !pwrite) ? rdVal : 32'h00000000;
        end
    end

endmodule : l1cd_top

`default_nettype wire

// ==== bench/l1cd_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "l1cd_cfg.svh"

module l1cd_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic transferStartN,
    input wire logic globalAttributeN,
    input wire logic [4:0] transferTypeCode,
    input wire logic [31:0] snoopAddr,
    input wire logic fillBeatValid,
    input wire logic [63:0] fillData,
    input wire logic fwdValid,
    input wire logic [63:0] fwdData,
    input wire l1cd_pkg::l1cd_busreq_s busReq,
    input wire logic copyBackReq,
    input wire logic [31:0] copyBackAddr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic cmdWr;
    logic snoopQ;
    assign cmdWr = psel && penable && pready && pwrite && (paddr == `L1CD_OFF_CMD);
    // Pins pass two sync flops, so the cause lies a few cycles back
    assign snoopQ = !transferStartN && !globalAttributeN;
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    fill_rwitm_a: assert property (busReq.req && busReq.global |-> busReq.rwitm)
        else $error("global fill not read with intent to modify");
    req_cause_a: assert property (busReq.req |-> $past(cmdWr))
        else $error("bus request without command");
    req_dword_a: assert property (busReq.req |-> busReq.addr[2:0] == 3'h0)
        else $error("fill address not double word aligned");
    fwd_first_a: assert property (fwdValid |-> $past(fillBeatValid) && fwdData == $past(fillData))
        else $error("forwarded data not first beat");
    cb_line_a: assert property (copyBackReq |-> copyBackAddr[4:0] == 5'h0)
        else $error("copy-back address not line aligned");
    cb_cause_a: assert property (copyBackReq |-> $past(snoopQ, 2) || $past(snoopQ, 3) || $past(snoopQ, 4))
        else $error("copy-back without qualified snoop");
    reset_quiet_a: assert property ($fell(sys_rst) |-> !busReq.req && !copyBackReq && !fwdValid)
        else $error("outputs active right after reset");
    cover property (busReq.req);
    cover property (copyBackReq);
    cover property (fwdValid);
    cover property (pslverr);
endmodule : l1cd_checker

bind l1cd_top l1cd_checker i_l1cd_checker (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .transferStartN, .globalAttributeN, .transferTypeCode,
    .snoopAddr, .fillBeatValid, .fillData, .fwdValid, .fwdData, .busReq, .copyBackReq,
    .copyBackAddr);

`default_nettype wire

// ==== bench/l1cd_peer.sv ====
`timescale 1ns/1ps
`default_nettype none

module l1cd_peer (
    input wire logic clk,
    input wire l1cd_pkg::l1cd_busreq_s busReq,
    input wire logic copyBackReq,
    input wire logic [31:0] copyBackAddr,
    output logic transferStartN,
    output logic globalAttributeN,
    output logic [4:0] transferTypeCode,
    output logic [31:0] snoopAddr,
    output logic fillBeatValid,
    output logic [63:0] fillData
);
    int gap = 1;
    int nFills = 0;
    int nReq = 0;
    int nCopy = 0;
    logic [31:0] reqAddr = 32'h0;
    logic reqGlobal = 1'b0;
    logic reqRwitm = 1'b0;
    logic [31:0] copyAddr = 32'h0;
    initial
    begin
        transferStartN = 1'b1;
        globalAttributeN = 1'b1;
        transferTypeCode = 5'h1f;
        snoopAddr = 32'h0;
        fillBeatValid = 1'b0;
        fillData = 64'h0;
    end
    // Memory side: four beats, critical double word first; gap stays >= 1
    always @(posedge clk)
    begin
        if (busReq.req === 1'b1)
        begin
            nReq++;
            reqAddr = busReq.addr;
            reqGlobal = busReq.global;
            reqRwitm = busReq.rwitm;
            for (int i = 0; i < 4; i++)
            begin
                repeat (gap) @(posedge clk);
                fillBeatValid <= 1'b1;
                fillData <= {32'h5a5a0000 | i, reqAddr};
                @(posedge clk);
                fillBeatValid <= 1'b0;
                fillData <= ~fillData;
            end
            nFills++;
        end
        if (copyBackReq === 1'b1)
        begin
            nCopy++;
            copyAddr = copyBackAddr;
        end
    end
    // Transfer start for one clock, with global only when g is set; start and global negated, type and address inverted after
    task automatic snoop(input logic g, input logic [4:0] tt, input logic [31:0] a);
        @(posedge clk);
        transferStartN <= 1'b0;
        globalAttributeN <= ~g;
        transferTypeCode <= tt;
        snoopAddr <= a;
        @(posedge clk);
        transferStartN <= 1'b1;
        globalAttributeN <= 1'b1;
        transferTypeCode <= ~tt;
        snoopAddr <= ~a;
    endtask : snoop
endmodule : l1cd_peer

`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "l1cd_cfg.svh"
`define CHK(nm, gt, ex) \
    begin \
        n_compared++; \
        if ((gt) !== (ex)) \
        begin \
            n_mismatch++; \
            $display("mismatch %s expected %h seen %h", nm, ex, gt); \
        end \
    end

module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic transferStartN;
    logic globalAttributeN;
    logic [4:0] transferTypeCode;
    logic [31:0] snoopAddr;
    logic fillBeatValid;
    logic [63:0] fillData;
    logic fwdValid;
    logic [63:0] fwdData;
    l1cd_pkg::l1cd_busreq_s busReq;
    logic copyBackReq;
    logic [31:0] copyBackAddr;
    logic [31:0] rdat;
    logic rerr;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int base;
    int nr;
    localparam logic [31:0] EA = 32'h00000a48;
    localparam logic [19:0] TAG = 20'h12345;
    localparam logic [31:0] LINE = {TAG, EA[11:5], 5'h0};

    l1cd_top i_l1cd_top (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .transferStartN, .globalAttributeN, .transferTypeCode, .snoopAddr,
        .fillBeatValid, .fillData, .fwdValid, .fwdData, .busReq, .copyBackReq, .copyBackAddr);
    l1cd_peer i_l1cd_peer (.clk, .busReq, .copyBackReq, .copyBackAddr, .transferStartN,
        .globalAttributeN, .transferTypeCode, .snoopAddr, .fillBeatValid, .fillData);

    always #25 clk = ~clk;

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run;
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic look(input logic [31:0] c, input logic [2:0] hs, input logic [2:0] w);
        apb(1'b1, `L1CD_OFF_CMD, c);
        apb(1'b0, `L1CD_OFF_STATUS, 32'h0);
        `CHK("state and hit", rdat[2:0], hs);
        if (hs[0])
            `CHK("way", rdat[5:3], w);
    endtask : look

    task automatic fill(input logic [31:0] c);
        int n;
        n = 0;
        base = i_l1cd_peer.nFills;
        apb(1'b1, `L1CD_OFF_CMD, c);
        while (i_l1cd_peer.nFills == base && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
    endtask : fill

    task automatic snp(input logic g, input logic [4:0] tt, input int dc);
        base = i_l1cd_peer.nCopy;
        i_l1cd_peer.snoop(g, tt, LINE + 32'h8);
        repeat (6) @(posedge clk);
        `CHK("copy-back count", i_l1cd_peer.nCopy - base, dc);
    endtask : snp

    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, `L1CD_OFF_CTRL, 32'h0);
        `CHK("ctrl reset", rdat[1:0], `L1CD_CTRL_RST);
        apb(1'b0, `L1CD_OFF_ATTR, 32'h0);
        `CHK("attr reset", rdat[17:0], `L1CD_ATTR_RST);
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", {rerr, rdat}, {1'b1, 32'h0});
        look(32'h1, 3'b000, 3'h0);
        `CHK("refused while clearing", rdat[9:7], 3'b100);
        base = 0;
        do
        begin
            apb(1'b0, `L1CD_OFF_STATUS, 32'h0);
            base++;
        end
        while (rdat[8:7] !== 2'h1 && base < 100);
        `CHK("idle after clear", rdat[8:7], 2'h1);
        `CHK("real mode attrs", rdat[24:17], {2{`L1CD_REAL_MODE_ATTR}});
        apb(1'b1, `L1CD_OFF_CTRL, 32'h3);
        apb(1'b1, `L1CD_OFF_ATTR, 32'h00010f20);
        apb(1'b0, `L1CD_OFF_STATUS, 32'h0);
        `CHK("block and page attrs", rdat[24:17], 8'h2e);
        apb(1'b1, `L1CD_OFF_EADDR, EA);
        apb(1'b1, `L1CD_OFF_PADDR, {12'h0, TAG});
        fill(32'h23);
        `CHK("fill addr", i_l1cd_peer.reqAddr, {TAG, EA[11:3], 3'h0});
        `CHK("global rwitm", {i_l1cd_peer.reqGlobal, i_l1cd_peer.reqRwitm}, 2'b11);
        `CHK("forwarded", fwdData, {32'h5a5a0000, TAG, EA[11:3], 3'h0});
        look(32'h1, 3'b011, 3'h2);
        apb(1'b1, `L1CD_OFF_PADDR, {12'h0, TAG + 20'h1});
        look(32'h1, 3'b000, 3'h0);
        apb(1'b1, `L1CD_OFF_PADDR, {12'h0, TAG});
        nr = i_l1cd_peer.nReq;
        apb(1'b1, `L1CD_OFF_CMD, 32'h4);
        look(32'h1, 3'b101, 3'h2);
        `CHK("store bus ops", i_l1cd_peer.nReq, nr);
        snp(1'b0, 5'h0a, 0);
        look(32'h1, 3'b101, 3'h2);
        snp(1'b1, 5'h0a, 1);
        `CHK("copy-back line", i_l1cd_peer.copyAddr, LINE);
        look(32'h1, 3'b011, 3'h2);
        snp(1'b1, 5'h1a, 0);
        look(32'h1, 3'b011, 3'h2);
        apb(1'b1, `L1CD_OFF_CMD, 32'h4);
        snp(1'b1, 5'h0e, 1);
        look(32'h1, 3'b000, 3'h0);
        i_l1cd_peer.gap = 3;
        fill(32'h23);
        snp(1'b1, 5'h0e, 0);
        look(32'h1, 3'b000, 3'h0);
        apb(1'b1, `L1CD_OFF_ATTR, 32'h00010f30);
        nr = i_l1cd_peer.nReq;
        apb(1'b1, `L1CD_OFF_CMD, 32'h123);
        apb(1'b0, `L1CD_OFF_STATUS, 32'h0);
        `CHK("guarded prefetch refused", rdat[9], 1'b1);
        repeat (4) @(posedge clk);
        `CHK("guarded bus ops", i_l1cd_peer.nReq, nr);
        apb(1'b1, `L1CD_OFF_CTRL, 32'h0);
        fill(32'h52);
        `CHK("instr fill", {i_l1cd_peer.reqGlobal, i_l1cd_peer.reqRwitm}, 2'b00);
        look(32'h0, 3'b011, 3'h5);
        `CHK("word select", rdat[13:11], EA[4:2]);
        snp(1'b1, 5'h0e, 0);
        look(32'h0, 3'b011, 3'h5);
        complete_run;
    end
endmodule : testbench

`undef CHK
`default_nettype wire
